// ---- core/tps_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the panel timing block
`ifndef TPS_REGS_SVH
`define TPS_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TPS_OFS_CTRL     8'h00
`define TPS_OFS_CLKDIV   8'h04
`define TPS_OFS_CLKPT    8'h08
`define TPS_OFS_HOR      8'h0c
`define TPS_OFS_HSYNC    8'h10
`define TPS_OFS_VER      8'h14
`define TPS_OFS_VSYNC    8'h18
`define TPS_OFS_WIN      8'h1c
`define TPS_OFS_PIXDIV   8'h20
`define TPS_OFS_STATUS   8'h24

// ----------------------------------------------------------------
// Control bits and field positions
// ----------------------------------------------------------------
`define TPS_CTRL_EN      0
`define TPS_CTRL_CLKINV  1
`define TPS_CTRL_HSINV   2
`define TPS_CTRL_VSINV   3
`define TPS_CTRL_DEINV   4
`define TPS_CTRL_VSLINE  5
`define TPS_CTRL_W       6
`define TPS_LO_LSB       0
`define TPS_HI_LSB       16
`define TPS_FLD_W        12
`define TPS_PIXDIV_W     8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TPS_RST_CTRL     6'h00
`define TPS_RST_PERIOD   12'h002
`define TPS_RST_BASE     12'h001
`define TPS_RST_FALL     12'h002
`define TPS_RST_RISE     12'h001
`define TPS_RST_LTOT     12'h00f
`define TPS_RST_SX       12'h002
`define TPS_RST_HSW      12'h000
`define TPS_RST_HSD      12'h000
`define TPS_RST_FTOT     12'h007
`define TPS_RST_SY       12'h001
`define TPS_RST_VSW      12'h000
`define TPS_RST_AW       12'h008
`define TPS_RST_AH       12'h004
`define TPS_RST_PIXDIV   8'h00

`endif

// ---- core/tps_pkg.sv ----
// Types shared by the panel timing block
package tps_pkg;
  typedef logic [11:0] tps_cnt_t;   // Pixel, line and time-setting width
  typedef logic [12:0] tps_time_t;  // Accumulated time within one interface period
  typedef logic [7:0]  tps_div_t;   // Pixel divider count
  typedef logic [23:0] tps_pix_t;   // One pixel toward the panel
endpackage : tps_pkg

// ---- core/tps_clk_if.sv ----
// Link between the timing core and its interface clock generator
`timescale 1ns/1ps
interface tps_clk_if;
  import tps_pkg::*;
  logic     en;      // Interface enabled
  tps_cnt_t period;  // Interface clock period setting
  tps_cnt_t base;    // Base clock period setting
  tps_cnt_t fall;    // Fall point setting
  tps_cnt_t rise;    // Rise point setting
  logic     tick;    // First base cycle of an interface period
  logic     low;     // Interface clock in its low phase

  modport gen (input en, period, base, fall, rise, output tick, low);
  modport core (output en, period, base, fall, rise, input tick, low);
endinterface : tps_clk_if

// ---- core/tps_clk_gen.sv ----
// Fractional interface clock generator on the base clock
`timescale 1ns/1ps
module tps_clk_gen
  import tps_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Core side
  tps_clk_if.gen    cif
);

  tps_time_t elap_q;  // Time elapsed since period start, in setting units
  logic      tick_q;
  logic      low_q;
  tps_time_t elap_nx;

  // ----------------------------------------------------------------
  // Period accumulator
  // ----------------------------------------------------------------
  // Remainder carried over, so fractional ratios alternate floor and floor+1
  assign elap_nx = elap_q + {1'b0, cif.base};

  always_ff @(posedge core_clk) begin
    if (!rst_n || !cif.en) begin
      elap_q <= '0;
      tick_q <= 1'b0;
    end else if (elap_nx >= {1'b0, cif.period}) begin
      elap_q <= elap_nx - {1'b0, cif.period};
      tick_q <= 1'b1;
    end else begin
      elap_q <= elap_nx;
      tick_q <= 1'b0;
    end
  end

  // Low phase spans rise point to fall point; a point is reached at the first
  // base cycle whose elapsed time covers it, which is the rounded-up point
  always_ff @(posedge core_clk) begin
    if (!rst_n || !cif.en) begin
      low_q <= 1'b0;
    end else begin
      low_q <= (elap_nx >= {1'b0, cif.rise}) && (elap_nx < {1'b0, cif.fall});
    end
  end

  assign cif.tick = tick_q;
  assign cif.low  = low_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_tick_rem;
    @(posedge core_clk) disable iff (!rst_n)
      cif.en && (elap_nx >= {1'b0, cif.period}) && $stable(cif.base) |=> elap_q < {1'b0, cif.base};
  endproperty
  a_tick_rem: assert property (p_tick_rem) else $error("period remainder too large");

endmodule : tps_clk_gen

// ---- core/tps_panel_timing.sv ----
// Raster timing generator for a memory-less active matrix TFT panel
// ----------------------------------------------------------------
// Functional notes
// - With straight clock polarity, data is stable so the panel takes it on the clock's fall.
// - While enabled the panel pixel clock runs without a gap between lines and frames.
// - One line sync pulse per line and one frame sync pulse per frame.
// - A frame sync pulse covers at least one full line sync pulse in line units, or in pixel units when its width is at least the line sync's.
// - Data valid is active only while valid pixel data is on the bus.
// - The pixel clock period is the interface period times the divider count plus one.
// - The interface period is the period setting over the base setting, dithered if fractional.
// - A line lasts total plus one pixels, line sync width plus one, after its delay.
// - A line holds a leading blank of start x, the active width, then the trailing blank.
// - A frame lasts total plus one lines, active lines start after start y lines.
// - Frame sync lasts width plus one pixels, or width plus one lines when line units are set.
// - The interface clock is low from the rise point to the fall point, high otherwise.
// - Pixel clock, line sync, frame sync and data valid polarities are each selectable.
// - Active width and height come from the feeding channel's window, not the raster settings.
// - Clock points are quantized upward to the base clock grid.
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "tps_regs.svh"
module tps_panel_timing
  import tps_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Pixel source
  input  wire tps_pix_t    pix_in,
  output logic             pix_take,
  // Panel pins
  output logic             panel_pixel_clock,
  output logic             panel_line_sync,
  output logic             panel_frame_sync,
  output logic             panel_data_valid,
  output tps_pix_t         panel_data
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [`TPS_CTRL_W-1:0] ctrl_q;
  tps_cnt_t period_q, base_q, fall_q, rise_q;
  tps_cnt_t ltot_q, sx_q, hsw_q, hsd_q;
  tps_cnt_t ftot_q, sy_q, vsw_q, aw_q, ah_q;
  tps_div_t pixdiv_q;
  tps_cnt_t hcnt_q, vcnt_q;
  tps_div_t pdiv_q;

  logic ctrl_en;
  assign ctrl_en = ctrl_q[`TPS_CTRL_EN];

  // Software writes; window size is the feeding channel's, kept apart from raster timing
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_q   <= `TPS_RST_CTRL;
      period_q <= `TPS_RST_PERIOD;
      base_q   <= `TPS_RST_BASE;
      fall_q   <= `TPS_RST_FALL;
      rise_q   <= `TPS_RST_RISE;
      ltot_q   <= `TPS_RST_LTOT;
      sx_q     <= `TPS_RST_SX;
      hsw_q    <= `TPS_RST_HSW;
      hsd_q    <= `TPS_RST_HSD;
      ftot_q   <= `TPS_RST_FTOT;
      sy_q     <= `TPS_RST_SY;
      vsw_q    <= `TPS_RST_VSW;
      aw_q     <= `TPS_RST_AW;
      ah_q     <= `TPS_RST_AH;
      pixdiv_q <= `TPS_RST_PIXDIV;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `TPS_OFS_CTRL:   ctrl_q <= reg_wdata[`TPS_CTRL_W-1:0];
        `TPS_OFS_CLKDIV: begin
          period_q <= reg_wdata[`TPS_LO_LSB +: `TPS_FLD_W];
          base_q   <= reg_wdata[`TPS_HI_LSB +: `TPS_FLD_W];
        end
        `TPS_OFS_CLKPT: begin
          fall_q <= reg_wdata[`TPS_LO_LSB +: `TPS_FLD_W];
          rise_q <= reg_wdata[`TPS_HI_LSB +: `TPS_FLD_W];
        end
        `TPS_OFS_HOR: begin
          ltot_q <= reg_wdata[`TPS_LO_LSB +: `TPS_FLD_W];
          sx_q   <= reg_wdata[`TPS_HI_LSB +: `TPS_FLD_W];
        end
        `TPS_OFS_HSYNC: begin
          hsw_q <= reg_wdata[`TPS_LO_LSB +: `TPS_FLD_W];
          hsd_q <= reg_wdata[`TPS_HI_LSB +: `TPS_FLD_W];
        end
        `TPS_OFS_VER: begin
          ftot_q <= reg_wdata[`TPS_LO_LSB +: `TPS_FLD_W];
          sy_q   <= reg_wdata[`TPS_HI_LSB +: `TPS_FLD_W];
        end
        `TPS_OFS_VSYNC:  vsw_q <= reg_wdata[`TPS_LO_LSB +: `TPS_FLD_W];
        `TPS_OFS_WIN: begin
          aw_q <= reg_wdata[`TPS_LO_LSB +: `TPS_FLD_W];
          ah_q <= reg_wdata[`TPS_HI_LSB +: `TPS_FLD_W];
        end
        `TPS_OFS_PIXDIV: pixdiv_q <= reg_wdata[`TPS_PIXDIV_W-1:0];
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge core_clk) begin
    if (!rst_n || !reg_rd) begin
      reg_rdata <= '0;
    end else begin
      unique case (reg_addr)
        `TPS_OFS_CTRL:   reg_rdata <= {26'h0000000, ctrl_q};
        `TPS_OFS_CLKDIV: reg_rdata <= {4'h0, base_q, 4'h0, period_q};
        `TPS_OFS_CLKPT:  reg_rdata <= {4'h0, rise_q, 4'h0, fall_q};
        `TPS_OFS_HOR:    reg_rdata <= {4'h0, sx_q, 4'h0, ltot_q};
        `TPS_OFS_HSYNC:  reg_rdata <= {4'h0, hsd_q, 4'h0, hsw_q};
        `TPS_OFS_VER:    reg_rdata <= {4'h0, sy_q, 4'h0, ftot_q};
        `TPS_OFS_VSYNC:  reg_rdata <= {20'h00000, vsw_q};
        `TPS_OFS_WIN:    reg_rdata <= {4'h0, ah_q, 4'h0, aw_q};
        `TPS_OFS_PIXDIV: reg_rdata <= {24'h000000, pixdiv_q};
        `TPS_OFS_STATUS: reg_rdata <= {4'h0, vcnt_q, 4'h0, hcnt_q};
        default:         reg_rdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interface clock generator
  // ----------------------------------------------------------------
  tps_clk_if cif ();
  assign cif.en     = ctrl_en;
  assign cif.period = period_q;
  assign cif.base   = base_q;
  assign cif.fall   = fall_q;
  assign cif.rise   = rise_q;

  tps_clk_gen u_clk_gen (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .cif      (cif)
  );

  // ----------------------------------------------------------------
  // Pixel divider and raster counters
  // ----------------------------------------------------------------
  logic pix_stb;
  logic stb_d_q;
  assign pix_stb = ctrl_en && cif.tick && (pdiv_q == pixdiv_q);

  // Divider counts interface periods within one pixel period
  always_ff @(posedge core_clk) begin
    if (!rst_n || !ctrl_en) begin
      pdiv_q <= '0;
    end else if (cif.tick) begin
      pdiv_q <= (pdiv_q == pixdiv_q) ? '0 : pdiv_q + 8'h01;
    end
  end

  // Horizontal and vertical position, advanced once per pixel period
  always_ff @(posedge core_clk) begin
    if (!rst_n || !ctrl_en) begin
      hcnt_q <= '0;
      vcnt_q <= '0;
    end else if (pix_stb) begin
      if (hcnt_q >= ltot_q) begin
        hcnt_q <= '0;
        vcnt_q <= (vcnt_q >= ftot_q) ? '0 : vcnt_q + 12'h001;
      end else begin
        hcnt_q <= hcnt_q + 12'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sync and window decode
  // ----------------------------------------------------------------
  logic [12:0] hs_end, vs_end, hx_end, vy_end;
  logic        hs_on, vs_on, de_on, clk_low;
  assign hs_end = {1'b0, hsd_q} + {1'b0, hsw_q};
  assign vs_end = {1'b0, hsd_q} + {1'b0, vsw_q};
  assign hx_end = {1'b0, sx_q} + {1'b0, aw_q};
  assign vy_end = {1'b0, sy_q} + {1'b0, ah_q};

  // Line sync starts after its delay; frame sync starts with the first line's sync in pixel units, at line 0's start in line units,
  // so a width of at least the line sync's width covers a whole line sync pulse
  assign hs_on = (hcnt_q >= hsd_q) && ({1'b0, hcnt_q} <= hs_end);
  assign vs_on = ctrl_q[`TPS_CTRL_VSLINE] ? (vcnt_q <= vsw_q)
               : (vcnt_q == 12'h000) && (hcnt_q >= hsd_q) && ({1'b0, hcnt_q} <= vs_end);
  assign de_on = (hcnt_q >= sx_q) && ({1'b0, hcnt_q} < hx_end)
              && (vcnt_q >= sy_q) && ({1'b0, vcnt_q} < vy_end);
  // Clock low phase only in the first interface period of each pixel period
  assign clk_low = ctrl_en && (pdiv_q == 8'h00) && cif.low;

  // ----------------------------------------------------------------
  // Panel outputs
  // ----------------------------------------------------------------
  logic clk_p1_q;

  // Clock delayed two cycles so it lines up with data; fall comes after data settles
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clk_p1_q          <= 1'b1;
      panel_pixel_clock <= 1'b1;
    end else begin
      clk_p1_q          <= !clk_low;
      panel_pixel_clock <= clk_p1_q ^ ctrl_q[`TPS_CTRL_CLKINV];
    end
  end

  // Syncs follow the counters one cycle later; disabled means inactive level
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      panel_line_sync  <= 1'b0;
      panel_frame_sync <= 1'b0;
      panel_data_valid <= 1'b0;
    end else begin
      panel_line_sync  <= (ctrl_en && hs_on) ^ ctrl_q[`TPS_CTRL_HSINV];
      panel_frame_sync <= (ctrl_en && vs_on) ^ ctrl_q[`TPS_CTRL_VSINV];
      panel_data_valid <= (ctrl_en && de_on) ^ ctrl_q[`TPS_CTRL_DEINV];
    end
  end

  // Data taken once per pixel, the cycle after the counters move; zero outside window
  always_ff @(posedge core_clk) begin
    if (!rst_n || !ctrl_en) begin
      stb_d_q    <= 1'b0;
      pix_take   <= 1'b0;
      panel_data <= '0;
    end else begin
      stb_d_q  <= pix_stb;
      pix_take <= stb_d_q && de_on;
      if (stb_d_q) begin
        panel_data <= de_on ? pix_in : '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_off2;
    !ctrl_en [*2];
  endsequence
  sequence s_line_end;
    pix_stb && (hcnt_q >= ltot_q);
  endsequence

  property p_pdiv_wrap;
    ctrl_en && pix_stb && $stable(ctrl_en) |=> pdiv_q == 8'h00;
  endproperty
  a_pdiv_wrap: assert property (p_pdiv_wrap) else $error("pixel divider did not wrap");

  property p_pdiv_hold;
    ctrl_en && !cif.tick ##1 ctrl_en |-> $stable(pdiv_q);
  endproperty
  a_pdiv_hold: assert property (p_pdiv_hold) else $error("divider moved off tick");

  // Pin shows the polarity that stood when the delayed low phase was launched
  property p_clk_low;
    clk_low |=> ##1 (panel_pixel_clock == $past(ctrl_q[`TPS_CTRL_CLKINV]));
  endproperty
  a_clk_low: assert property (p_clk_low) else $error("pixel clock not low");

  property p_line_wrap;
    (s_line_end and ctrl_en) ##1 ctrl_en |-> hcnt_q == 12'h000;
  endproperty
  a_line_wrap: assert property (p_line_wrap) else $error("line did not wrap");

  property p_frame_wrap;
    (s_line_end and (ctrl_en && (vcnt_q >= ftot_q))) ##1 ctrl_en |-> vcnt_q == 12'h000;
  endproperty
  a_frame_wrap: assert property (p_frame_wrap) else $error("frame did not wrap");

  property p_hs;
    ctrl_en && hs_on |=> panel_line_sync != $past(ctrl_q[`TPS_CTRL_HSINV]);
  endproperty
  a_hs: assert property (p_hs) else $error("line sync missing");

  property p_vs_line;
    ctrl_en && ctrl_q[`TPS_CTRL_VSLINE] && (vcnt_q <= vsw_q)
      |=> panel_frame_sync != $past(ctrl_q[`TPS_CTRL_VSINV]);
  endproperty
  a_vs_line: assert property (p_vs_line) else $error("frame sync missing");

  property p_de;
    ctrl_en && !de_on |=> panel_data_valid == $past(ctrl_q[`TPS_CTRL_DEINV]);
  endproperty
  a_de: assert property (p_de) else $error("valid outside window");

  property p_off;
    s_off2 |-> (hcnt_q == 12'h000) && (vcnt_q == 12'h000)
      && (panel_line_sync == $past(ctrl_q[`TPS_CTRL_HSINV])) && !pix_take;
  endproperty
  a_off: assert property (p_off) else $error("disabled block still active");

endmodule : tps_panel_timing

// ---- test/tps_panel_model.sv ----
// Memory-less panel model: takes pixels and measures sync timing
`timescale 1ns/1ps
module tps_panel_model
  import tps_pkg::*;
(
  // Clock and reset
  input  wire logic     core_clk,
  input  wire logic     rst_n,
  // Panel pins
  input  wire logic     panel_pixel_clock,
  input  wire logic     panel_line_sync,
  input  wire logic     panel_frame_sync,
  input  wire logic     panel_data_valid,
  input  wire tps_pix_t panel_data,
  // Measurements
  output int            ls_cnt,
  output int            fs_cnt,
  output int            pix_cnt,
  output int            pf_cnt,
  output int            bad_seq,
  output int            ls_gap,
  output int            fs_gap,
  output int            ls_len,
  output int            fs_len,
  output int            fs_cov
);
  logic     pclk_q, ls_q, fs_q, seen_q;
  tps_pix_t last_q;
  int       now, ls_t, fs_t, ls_hi, fs_hi, cov;

  // ----------------------------------------------------------------
  // Capture and measurement, straight polarity only
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      {pclk_q, ls_q, fs_q, seen_q} <= 4'b1000;
      {ls_cnt, fs_cnt, pix_cnt, pf_cnt, bad_seq} <= '0;
      {now, ls_t, fs_t, ls_hi, fs_hi, cov} <= '0;
      {ls_gap, fs_gap, ls_len, fs_len, fs_cov} <= '0;
      last_q <= 24'h0;
    end else begin
      now    <= now + 1;
      pclk_q <= panel_pixel_clock;
      ls_q   <= panel_line_sync;
      fs_q   <= panel_frame_sync;
      // Panel takes data on the falling clock edge, only while valid
      if (pclk_q && !panel_pixel_clock) begin
        pf_cnt <= pf_cnt + 1;
        if (panel_data_valid) begin
          pix_cnt <= pix_cnt + 1;
          if (seen_q && panel_data !== last_q + 24'h1) bad_seq <= bad_seq + 1;
          last_q <= panel_data;
          seen_q <= 1'b1;
        end
      end
      // Line sync spacing and width
      if (panel_line_sync && !ls_q) begin
        ls_cnt <= ls_cnt + 1;
        ls_gap <= now - ls_t;
        ls_t   <= now;
        ls_hi  <= 1;
      end else if (panel_line_sync) ls_hi <= ls_hi + 1;
      if (!panel_line_sync && ls_q) ls_len <= ls_hi;
      // Frame sync spacing, width and line syncs inside it
      if (panel_frame_sync && !fs_q) begin
        fs_cnt <= fs_cnt + 1;
        fs_gap <= now - fs_t;
        fs_t   <= now;
        fs_hi  <= 1;
        cov    <= (panel_line_sync && !ls_q) ? 1 : 0;
        // A pixel taken just before a disable never reaches the glass; restart order check
        if (!panel_data_valid) seen_q <= 1'b0;
      end else if (panel_frame_sync) begin
        fs_hi <= fs_hi + 1;
        if (panel_line_sync && !ls_q) cov <= cov + 1;
      end
      if (!panel_frame_sync && fs_q) begin
        fs_len <= fs_hi;
        fs_cov <= cov;
      end
    end
  end
endmodule : tps_panel_model

// ---- test/tb.sv ----
// Self-checking bench for the panel timing block
`timescale 1ns/1ps
`include "tps_regs.svh"
`define CHK(nm, exp, got) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("BAD %s exp %0h got %0h", nm, exp, got); \
  end \
end
module tb
  import tps_pkg::*;
;
  typedef struct {
    logic [31:0] clkdiv, clkpt, pixdiv, win, hsync, vsync, ctrl;
    int          pix, pf, lsg, fsg, lsl, fsl;
  } tps_row_s;
  // Timing setups beside the raster they should give
  tps_row_s rows [4] = '{
    '{32'h0001_0002, 32'h0001_0002, 32'h0, 32'h0004_0008, 32'h0, 32'h0, 32'h01,
      32, 128, 32, 256, 2, 2},
    '{32'h0001_0002, 32'h0001_0002, 32'h1, 32'h0004_0008, 32'h0, 32'h0, 32'h01,
      32, 128, 64, 512, 4, 4},
    // Dithered 1.5-cycle period needs two of them per pixel to fit a low phase
    '{32'h0002_0003, 32'h0002_0003, 32'h1, 32'h0004_0008, 32'h1, 32'h1, 32'h21,
      32, 128, 48, 384, 6, 96},
    '{32'h0001_0002, 32'h0001_0002, 32'h0, 32'h0002_0005, 32'h0001_0002, 32'h2, 32'h01,
      10, 128, 32, 256, 6, 6}};
  // Reset contents of the register map, last one unmapped
  logic [7:0]  ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h28};
  logic [31:0] rv [10] = '{32'h0, 32'h0001_0002, 32'h0001_0002, 32'h0002_000f, 32'h0,
                           32'h0001_0007, 32'h0, 32'h0004_0008, 32'h0, 32'h0};

  logic        core_clk, rst_n, reg_wr, reg_rd, pix_take;
  logic        panel_pixel_clock, panel_line_sync, panel_frame_sync, panel_data_valid;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  tps_pix_t    pix_in, panel_data;
  int          ls_cnt, fs_cnt, pix_cnt, pf_cnt, bad_seq, ls_gap, fs_gap, ls_len, fs_len, fs_cov;
  int          miscompares, tests_run, cyc, p0, f0, l0;

  // ----------------------------------------------------------------
  // Design and panel
  // ----------------------------------------------------------------
  tps_panel_timing uut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pix_in(pix_in), .pix_take(pix_take), .panel_pixel_clock(panel_pixel_clock),
    .panel_line_sync(panel_line_sync), .panel_frame_sync(panel_frame_sync),
    .panel_data_valid(panel_data_valid), .panel_data(panel_data));
  tps_panel_model panel (.core_clk(core_clk), .rst_n(rst_n),
    .panel_pixel_clock(panel_pixel_clock), .panel_line_sync(panel_line_sync),
    .panel_frame_sync(panel_frame_sync), .panel_data_valid(panel_data_valid),
    .panel_data(panel_data), .ls_cnt(ls_cnt), .fs_cnt(fs_cnt), .pix_cnt(pix_cnt),
    .pf_cnt(pf_cnt), .bad_seq(bad_seq), .ls_gap(ls_gap), .fs_gap(fs_gap),
    .ls_len(ls_len), .fs_len(fs_len), .fs_cov(fs_cov));

  // ----------------------------------------------------------------
  // Clock, pixel source and hang guard
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Source counts up so the panel can spot a lost or repeated pixel
  always @(posedge core_clk) begin
    if (!rst_n) pix_in <= 24'h0;
    else if (pix_take) pix_in <= pix_in + 24'h1;
  end

  // Longest row spans two frames of 512 cycles; ceiling leaves ample margin
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // Register bus: strobe for one cycle, then let one edge pass
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    `CHK("rdata", e, reg_rdata)
    @(posedge core_clk);
  endtask : rd

  task automatic frames(input int n);
    int t0;
    t0 = fs_cnt;
    while (fs_cnt < t0 + n) @(posedge core_clk);
  endtask : frames

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n       = 1'b0;
    reg_addr    = 8'h00;
    reg_wdata   = 32'h0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    miscompares = 0;
    tests_run   = 0;
    cyc         = 0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    `CHK("pclk", 1'b1, panel_pixel_clock)
    `CHK("lsync", 1'b0, panel_line_sync)
    `CHK("fsync", 1'b0, panel_frame_sync)
    `CHK("valid", 1'b0, panel_data_valid)
    `CHK("data", 24'h0, panel_data)
    @(posedge core_clk);
    foreach (ra[i]) rd(ra[i], rv[i]);
    repeat (40) @(posedge core_clk);
    `CHK("idle", 0, ls_cnt + pf_cnt)
    foreach (rows[i]) begin
      // Stop the raster first so no half-set timing reaches the panel
      wr(`TPS_OFS_CTRL, 32'h0);
      wr(`TPS_OFS_CLKDIV, rows[i].clkdiv);
      wr(`TPS_OFS_CLKPT, rows[i].clkpt);
      wr(`TPS_OFS_PIXDIV, rows[i].pixdiv);
      wr(`TPS_OFS_WIN, rows[i].win);
      wr(`TPS_OFS_HSYNC, rows[i].hsync);
      wr(`TPS_OFS_VSYNC, rows[i].vsync);
      wr(`TPS_OFS_CTRL, rows[i].ctrl);
      frames(2);
      p0 = pix_cnt;
      f0 = pf_cnt;
      l0 = ls_cnt;
      frames(1);
      `CHK("pixels", rows[i].pix, pix_cnt - p0)
      `CHK("pclk_falls", rows[i].pf, pf_cnt - f0)
      `CHK("lines", 8, ls_cnt - l0)
      `CHK("line_gap", rows[i].lsg, ls_gap)
      `CHK("frame_gap", rows[i].fsg, fs_gap)
      `CHK("line_len", rows[i].lsl, ls_len)
      `CHK("frame_len", rows[i].fsl, fs_len)
      `CHK("cover", 1'b1, fs_cov > 0)
    end
    `CHK("sequence", 0, bad_seq)
    // Disable in mid-frame: outputs drop and counters clear
    repeat (50) @(posedge core_clk);
    wr(`TPS_OFS_CTRL, 32'h0);
    @(negedge core_clk);
    `CHK("lsync", 1'b0, panel_line_sync)
    `CHK("fsync", 1'b0, panel_frame_sync)
    `CHK("valid", 1'b0, panel_data_valid)
    @(posedge core_clk);
    rd(`TPS_OFS_STATUS, 32'h0);
    // Every polarity inverted while idle
    wr(`TPS_OFS_CTRL, 32'h1e);
    @(negedge core_clk);
    `CHK("pclk", 1'b0, panel_pixel_clock)
    `CHK("lsync", 1'b1, panel_line_sync)
    `CHK("fsync", 1'b1, panel_frame_sync)
    `CHK("valid", 1'b1, panel_data_valid)
    summarize();
  end
endmodule : tb
